// ===== src/epv_pkg.sv
// Constants and types shared by the exception sequencing unit
package epv_pkg;

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int          SR_T_BIT      = 15;
    localparam int          SR_MASK_LSB   = 8;
    localparam int          MASK_W        = 3;
    localparam logic [2:0]  MASK_RESET    = 3'h7;
    localparam logic        T_RESET       = 1'b0;

    // ------------------------------------------------------------------
    // Vector numbers (entry index; byte address = index * entry size)
    // ------------------------------------------------------------------
    localparam int          VN_W          = 6;
    localparam logic [5:0]  VN_INVALID    = 6'h02;
    localparam logic [5:0]  VN_ZERO_DIV   = 6'h03;
    localparam logic [5:0]  VN_OVF_TRAP   = 6'h04;
    localparam logic [5:0]  VN_ADDR_ERR   = 6'h08;
    localparam logic [5:0]  VN_TRACE      = 6'h09;
    localparam logic [5:0]  VN_TRAP_BASE  = 6'h10;

    // ------------------------------------------------------------------
    // Vector table geometry
    // ------------------------------------------------------------------
    localparam logic [15:0] RESET_VEC     = 16'h0000;
    localparam logic [15:0] MAX_PC_OFS    = 16'h0002;
    localparam logic [15:0] MIN_PC_OFS    = 16'h0000;
    localparam logic [7:0]  CP_RESET      = 8'h00;

    typedef enum logic [2:0] {
        CL_NONE,
        CL_ADDR,
        CL_TRACE,
        CL_IRQ,
        CL_INSN
    } epv_class_t;

    typedef enum logic [2:0] {
        S_HOLD,
        S_IDLE,
        S_PUSH_PC,
        S_PUSH_CP,
        S_PUSH_SR,
        S_VEC_CP,
        S_VEC_PC,
        S_BRANCH
    } epv_state_t;

endpackage : epv_pkg

// ===== src/epv_sel_if.sv
// Arbitration and vector lookup signals between the sequencer parts
`timescale 1ns/10ps
`default_nettype none
interface epv_sel_if;
    import epv_pkg::*;
    logic             addr_req;
    logic             trace_req;
    logic             irq_req;
    logic             insn_req;
    epv_class_t       grant;
    logic [VN_W-1:0]  vec_num;
    logic             max_mode;
    logic [15:0]      vec_addr;

    modport arb  (input addr_req, trace_req, irq_req, insn_req,
                  output grant);
    modport vec  (input vec_num, max_mode, output vec_addr);
    modport core (output addr_req, trace_req, irq_req, insn_req,
                  output vec_num, max_mode,
                  input grant, vec_addr);
endinterface : epv_sel_if
`default_nettype wire

// ===== src/epv_arbiter.sv
// Fixed priority ranking of pending exception requests
`timescale 1ns/10ps
`default_nettype none
module epv_arbiter
    import epv_pkg::*;
(
    epv_sel_if.arb sel
);
    // Instruction exceptions never coincide with others, so they
    // simply sit at the head of the ranked chain
    assign sel.grant = sel.insn_req  ? CL_INSN  :
                       sel.addr_req  ? CL_ADDR  :
                       sel.trace_req ? CL_TRACE :
                       sel.irq_req   ? CL_IRQ   :
                                       CL_NONE;
endmodule : epv_arbiter
`default_nettype wire

// ===== src/epv_vector.sv
// Vector table address from entry index and addressing mode
`timescale 1ns/10ps
`default_nettype none
module epv_vector
    import epv_pkg::*;
(
    epv_sel_if.vec sel
);
    wire [15:0] min_addr = {9'h000, sel.vec_num, 1'b0};
    wire [15:0] max_addr = {8'h00, sel.vec_num, 2'b00};

    // Two-byte entries in minimum mode, four in maximum mode
    assign sel.vec_addr = sel.max_mode ? max_addr : min_addr;
endmodule : epv_vector
`default_nettype wire

// ===== src/epv_exc_unit.sv
// Exception priority and vectoring sequencer of the CPU
// How it works
// - Handle reset, address error, trace, interrupt, instruction
// - Instruction causes: undefined, trap, zero divide
// - Priority: reset, address error, trace, interrupt
// - Instruction exceptions never coincide with others
// - Address error handled after current instruction ends
// - Trace after each instruction while trace enabled
// - Interrupts sampled at instruction or sequence end
// - Undefined opcode raises invalid-instruction exception
// - Divide by zero raises zero-divide exception
// - Stack PC, code page (maximum), status word
// - Clear trace enable after stacking
// - Fetch vector, then branch to handler
// - Interrupts also update the mask level
// - Reset starts on pin rise, no stacking
// - Vector table starts at address zero
// - Entries two bytes minimum, four maximum
// - Instruction vectors at their fixed entries
// - Address error, trace, interrupt vector entries
// - Trap instruction selects one of sixteen
// - Reset clears trace, sets mask seven
// - Maximum reset: code page byte one, PC word two
// - Address error keeps the mask level
`timescale 1ns/10ps
`default_nettype none
module epv_exc_unit
    import epv_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        max_mode_i,
    input  wire logic        insn_end_i,
    input  wire logic        addr_err_i,
    input  wire logic        undefined_op_i,
    input  wire logic        unconditional_trap_op_i,
    input  wire logic [3:0]  trap_num_i,
    input  wire logic        overflow_trap_op_i,
    input  wire logic        unsigned_divide_op_i,
    input  wire logic        divisor_zero_i,
    input  wire logic        irq_req_i,
    input  wire logic [5:0]  irq_vec_i,
    input  wire logic [2:0]  irq_level_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  code_page_reg_i,
    input  wire logic [15:0] status_word_i,
    input  wire logic        sr_load_i,
    input  wire logic [15:0] sr_load_val_i,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_rdata_i,
    output logic             seq_busy_o,
    output logic             mem_req_o,
    output logic             mem_push_o,
    output logic [15:0]      mem_addr_o,
    output logic [15:0]      mem_wdata_o,
    output logic             branch_o,
    output logic [15:0]      branch_pc_o,
    output logic [7:0]       branch_cp_o,
    output logic             trace_en_o,
    output logic [2:0]       interrupt_mask_level_o,
    output logic             irq_ack_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    epv_state_t   state;
    epv_state_t   next_state;
    epv_class_t   cls;
    logic         reset_prev;
    logic         mode_max;
    logic         addr_pend;
    logic         trace_pend;
    logic         seq_done;
    logic [15:0]  vaddr;
    logic [2:0]   irq_lvl;

    epv_sel_if sel ();

    epv_arbiter u_arb (
        .sel (sel)
    );

    epv_vector u_vec (
        .sel (sel)
    );

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    wire reset_rise = reset_pin_n_i & ~reset_prev;
    wire zero_div   = unsigned_divide_op_i & divisor_zero_i;
    wire insn_exc   = undefined_op_i | unconditional_trap_op_i
                    | overflow_trap_op_i | zero_div;
    wire trace_new  = insn_end_i & trace_en_o;
    wire in_idle    = (state == S_IDLE);
    // Decisions only at instruction or sequence boundaries
    wire boundary   = in_idle & (insn_end_i | seq_done | insn_exc);
    wire start      = boundary & (sel.grant != CL_NONE)
                    & reset_pin_n_i;
    wire ack_sr     = (state == S_PUSH_SR) & mem_ack_i;
    wire ack_pc     = (state == S_VEC_PC) & mem_ack_i;

    assign sel.addr_req  = addr_pend | addr_err_i;
    assign sel.trace_req = trace_pend | trace_new;
    assign sel.irq_req   = irq_req_i;
    assign sel.insn_req  = insn_exc;
    assign sel.max_mode  = mode_max;

    wire [5:0] trap_vn = VN_TRAP_BASE | {2'b00, trap_num_i};
    wire [5:0] insn_vn = undefined_op_i     ? VN_INVALID  :
                         overflow_trap_op_i ? VN_OVF_TRAP :
                         zero_div           ? VN_ZERO_DIV :
                                              trap_vn;
    assign sel.vec_num = (sel.grant == CL_INSN)  ? insn_vn     :
                         (sel.grant == CL_ADDR)  ? VN_ADDR_ERR :
                         (sel.grant == CL_TRACE) ? VN_TRACE    :
                                                   irq_vec_i;

    wire [15:0] next_vaddr = start      ? sel.vec_addr :
                             reset_rise ? RESET_VEC    :
                                          vaddr;
    wire        next_mode  = reset_rise ? max_mode_i : mode_max;
    wire [15:0] pc_ofs     = next_mode ? MAX_PC_OFS : MIN_PC_OFS;

    // Stacked copy carries the live trace and mask values
    wire [15:0] stacked_sr = {trace_en_o, status_word_i[14:11],
                              interrupt_mask_level_o,
                              status_word_i[7:0]};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_HOLD: begin
                if (reset_rise) begin
                    // Reset goes straight to the vector fetch
                    next_state = next_mode ? S_VEC_CP : S_VEC_PC;
                end
            end
            S_IDLE: begin
                if (start) begin
                    next_state = S_PUSH_PC;
                end
            end
            S_PUSH_PC: begin
                if (mem_ack_i) begin
                    next_state = mode_max ? S_PUSH_CP : S_PUSH_SR;
                end
            end
            S_PUSH_CP: begin
                if (mem_ack_i) begin
                    next_state = S_PUSH_SR;
                end
            end
            S_PUSH_SR: begin
                if (mem_ack_i) begin
                    next_state = mode_max ? S_VEC_CP : S_VEC_PC;
                end
            end
            S_VEC_CP: begin
                if (mem_ack_i) begin
                    next_state = S_VEC_PC;
                end
            end
            S_VEC_PC: begin
                if (mem_ack_i) begin
                    next_state = S_BRANCH;
                end
            end
            S_BRANCH: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // Pin low overrides everything
        if (!reset_pin_n_i) begin
            next_state = S_HOLD;
        end
    end

    // ------------------------------------------------------------------
    // Memory command, registered from the next state
    // ------------------------------------------------------------------
    wire next_push = (next_state == S_PUSH_PC) | (next_state == S_PUSH_CP)
                   | (next_state == S_PUSH_SR);
    wire next_rd   = (next_state == S_VEC_CP) | (next_state == S_VEC_PC);
    wire [15:0] next_addr  = (next_state == S_VEC_CP) ? next_vaddr :
                             (next_state == S_VEC_PC) ?
                                 16'(next_vaddr + pc_ofs) : 16'h0000;
    wire [15:0] next_wdata = (next_state == S_PUSH_PC) ? pc_i :
                             (next_state == S_PUSH_CP) ?
                                 {8'h00, code_page_reg_i} :
                             (next_state == S_PUSH_SR) ? stacked_sr :
                                                         16'h0000;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state       <= S_HOLD;
            mem_req_o   <= 1'b0;
            mem_push_o  <= 1'b0;
            mem_addr_o  <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            seq_busy_o  <= 1'b1;
        end else begin
            state       <= next_state;
            mem_req_o   <= next_push | next_rd;
            mem_push_o  <= next_push;
            mem_addr_o  <= next_addr;
            mem_wdata_o <= next_wdata;
            seq_busy_o  <= (next_state != S_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Pending requests; a take clears its own new event, except an address error arriving while one is already pending
    // ------------------------------------------------------------------
    wire take_addr  = start & (sel.grant == CL_ADDR);
    wire take_trace = start & (sel.grant == CL_TRACE);

    always_ff @(posedge mclk_i) begin
        if (srst_i || !reset_pin_n_i) begin
            addr_pend  <= 1'b0;
            trace_pend <= 1'b0;
        end else begin
            // An error in the taking cycle is served by that same take unless one was already pending
            addr_pend  <= (addr_err_i & ~(take_addr & ~addr_pend))
                        | (addr_pend & ~take_addr);
            trace_pend <= (trace_new & ~take_trace)
                        | (trace_pend & ~take_trace);
        end
    end

    // ------------------------------------------------------------------
    // Sequence context and status word fields
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reset_prev <= 1'b0;
            mode_max   <= 1'b0;
            vaddr      <= RESET_VEC;
            cls        <= CL_NONE;
            irq_lvl    <= MASK_RESET;
            irq_ack_o  <= 1'b0;
            seq_done   <= 1'b0;
        end else begin
            reset_prev <= reset_pin_n_i;
            mode_max   <= next_mode;
            vaddr      <= next_vaddr;
            cls        <= start ? sel.grant : cls;
            irq_lvl    <= start ? irq_level_i : irq_lvl;
            irq_ack_o  <= start & (sel.grant == CL_IRQ);
            seq_done   <= (state == S_BRANCH);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            trace_en_o             <= T_RESET;
            interrupt_mask_level_o <= MASK_RESET;
        end else if (reset_rise) begin
            trace_en_o             <= T_RESET;
            interrupt_mask_level_o <= MASK_RESET;
        end else if (ack_sr) begin
            trace_en_o             <= 1'b0;
            if (cls == CL_IRQ) begin
                interrupt_mask_level_o <= irq_lvl;
            end
        end else if (sr_load_i && in_idle) begin
            trace_en_o             <= sr_load_val_i[SR_T_BIT];
            interrupt_mask_level_o <=
                sr_load_val_i[SR_MASK_LSB +: MASK_W];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            branch_o    <= 1'b0;
            branch_pc_o <= 16'h0000;
            branch_cp_o <= CP_RESET;
        end else begin
            branch_o    <= ack_pc;
            if (ack_pc) begin
                branch_pc_o <= mem_rdata_i;
            end
            if ((state == S_VEC_CP) && mem_ack_i) begin
                branch_cp_o <= mem_rdata_i[7:0];
            end else if (reset_rise && !next_mode) begin
                branch_cp_o <= CP_RESET;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_reset_status_init: assert property (
        reset_rise |=> !trace_en_o && interrupt_mask_level_o == MASK_RESET)
        else $error("reset did not init trace and mask");
    a_reset_no_stack: assert property (
        (state == S_HOLD && reset_rise) |=> mem_req_o && !mem_push_o)
        else $error("reset sequence stacked context");
    a_reset_vec_zero: assert property (
        (state == S_HOLD && reset_rise) |=> mem_addr_o == RESET_VEC
            + ($past(max_mode_i) ? 16'h0000 : MIN_PC_OFS))
        else $error("reset vector not at zero");
    a_max_pc_word: assert property (
        (state == S_VEC_PC && mode_max) |->
            mem_addr_o == 16'(vaddr + MAX_PC_OFS))
        else $error("maximum mode PC word misplaced");
    a_push_pc_first: assert property (
        start |=> mem_push_o && mem_wdata_o == $past(pc_i))
        else $error("sequence did not stack PC first");
    a_seq_clear_trace: assert property (
        ack_sr |=> !trace_en_o)
        else $error("trace bit not cleared after stacking");
    a_mask_kept: assert property (
        (ack_sr && cls != CL_IRQ) |=>
            $stable(interrupt_mask_level_o))
        else $error("non-interrupt sequence changed mask");
    a_irq_mask_set: assert property (
        (ack_sr && cls == CL_IRQ) |=> interrupt_mask_level_o == irq_lvl)
        else $error("interrupt mask not updated");
    a_addr_over_trace: assert property (
        (start && sel.addr_req && !insn_exc) |=> cls == CL_ADDR)
        else $error("address error lost priority");
    a_pend_kept: assert property (
        (addr_pend && !boundary && reset_pin_n_i) |=> addr_pend)
        else $error("pending address error dropped");
    a_branch_target: assert property (
        ack_pc |=> branch_o && branch_pc_o == $past(mem_rdata_i)
            ##1 !branch_o && !seq_busy_o)
        else $error("branch not taken to fetched vector");

    c_reset_seq:  cover property (reset_rise ##[1:20] branch_o);
    c_trace_seq:  cover property (start && sel.grant == CL_TRACE);
    c_irq_seq:    cover property (irq_ack_o ##[1:40] branch_o);
    c_max_push:   cover property (state == S_PUSH_CP && mem_ack_i);

endmodule : epv_exc_unit
`default_nettype wire

// ===== sim/epv_mem_model.sv
// Memory partner answering stack pushes and vector reads
`timescale 1ns/10ps
`default_nettype none
module epv_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_push_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [1:0]  lat_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    logic [1:0] wait_cnt;

    function automatic logic [15:0] vec_word(input logic [15:0] a);
        return (a * 16'h0101) ^ 16'hc35a;
    endfunction : vec_word

    initial begin
        mem_ack_o   = 1'b0;
        mem_rdata_o = 16'h0000;
        wait_cnt    = 2'h0;
    end

    // ------------------------------------------------------------------
    // Falling-edge answer; data toggles whenever it is not valid
    // ------------------------------------------------------------------
    always @(negedge mclk_i) begin
        if (mem_ack_o) begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            wait_cnt    <= lat_i;
        end else if (mem_req_i && wait_cnt == 2'h0) begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= mem_push_i ? ~mem_rdata_o : vec_word(mem_addr_i);
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i) wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule : epv_mem_model
`default_nettype wire

// ===== sim/exception_priority_vectoring_test.sv
// Self-checking bench of the exception sequencing unit
`timescale 1ns/10ps
`default_nettype none
module exception_priority_vectoring_test;
    import epv_pkg::*;
    logic        mclk_i = 0, srst_i = 1, pin_n = 1, mx = 0, iend = 0;
    logic        aerr = 0, undef = 0, unconditional_trap_op = 0, ovf = 0, divu = 0, dz = 0;
    logic        irq = 0, srld = 0, ack, brs = 0, acks = 0, t = 0, mmode;
    logic        busy, req, push, br, ten, iack;
    logic [3:0]  tnum = 0;
    logic [5:0]  ivec = 0;
    logic [2:0]  ilvl = 0, msk = 7, mlv;
    logic [15:0] pc = 0, sw = 0, srv = 0, rd, addr, wd, bpc;
    logic [7:0]  cp = 0, bcp;
    logic [1:0]  lat = 0;
    logic [32:0] q[$], e[$];
    logic [31:0] rs = 45;
    int          mismatches = 0, tests_run = 0, cyc = 0;

    epv_exc_unit i_epv_exc_unit (.mclk_i(mclk_i), .srst_i(srst_i),
        .reset_pin_n_i(pin_n), .max_mode_i(mx), .insn_end_i(iend),
        .addr_err_i(aerr), .undefined_op_i(undef),
        .unconditional_trap_op_i(unconditional_trap_op), .trap_num_i(tnum),
        .overflow_trap_op_i(ovf), .unsigned_divide_op_i(divu),
        .divisor_zero_i(dz), .irq_req_i(irq), .irq_vec_i(ivec),
        .irq_level_i(ilvl), .pc_i(pc), .code_page_reg_i(cp),
        .status_word_i(sw), .sr_load_i(srld), .sr_load_val_i(srv),
        .mem_ack_i(ack), .mem_rdata_i(rd), .seq_busy_o(busy),
        .mem_req_o(req), .mem_push_o(push), .mem_addr_o(addr),
        .mem_wdata_o(wd), .branch_o(br), .branch_pc_o(bpc),
        .branch_cp_o(bcp), .trace_en_o(ten),
        .interrupt_mask_level_o(mlv), .irq_ack_o(iack));
    epv_mem_model i_epv_mem_model (.mclk_i(mclk_i), .mem_req_i(req),
        .mem_push_i(push), .mem_addr_i(addr), .lat_i(lat),
        .mem_ack_o(ack), .mem_rdata_o(rd));

    always #20 mclk_i = ~mclk_i;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs

    function automatic logic [15:0] vec_word(input logic [15:0] a);
        return (a * 16'h0101) ^ 16'hc35a;
    endfunction : vec_word

    task automatic check(input string n, input logic [32:0] s, x);
        tests_run++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // Command log taken at the consuming edge only
    always @(posedge mclk_i) begin
        cyc++;
        if (req && ack) q.push_back({push, addr, push ? wd : 16'h0});
        if (br) brs = 1;
        if (iack) acks = 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // k: 0 reset, 1 other exception, 2 interrupt
    task automatic run_seq(input logic [5:0] vn, input int k);
        logic [15:0] va;
        logic [15:0] w;
        lat = 2'(xs());
        va = mmode ? 16'(vn) << 2 : 16'(vn) << 1;
        e = {};
        if (k == 0) begin
            va = 16'h0000;
            t = 0;
            msk = 7;
        end else begin
            e.push_back({1'b1, 16'h0, pc});
            if (mmode) e.push_back({1'b1, 16'h0, 8'h00, cp});
            e.push_back({1'b1, 16'h0, t, sw[14:11], msk, sw[7:0]});
        end
        if (mmode) e.push_back({1'b0, va, 16'h0});
        e.push_back({1'b0, va + (mmode ? 16'h2 : 16'h0), 16'h0});
        for (int i = 0; i < 200 && !brs; i++) begin
            @(negedge mclk_i);
            if (acks) irq = 0;
        end
        check("count", 33'(q.size()), 33'(e.size()));
        foreach (e[i]) check("cmd", q[i], e[i]);
        w = vec_word(va + (mmode ? 16'h2 : 16'h0));
        check("pc", 33'(bpc), 33'(w));
        w = vec_word(va);
        if (mmode) check("cp", 33'(bcp), 33'(w[7:0]));
        if (k == 2) msk = ilvl;
        t = 0;
        check("trace", 33'(ten), 33'(t));
        check("mask", 33'(mlv), 33'(msk));
        check("ack", 33'(acks), 33'(k == 2));
        q = {};
        brs = 0;
        acks = 0;
    endtask : run_seq

    task automatic pulse(input int k);
        @(negedge mclk_i);
        tnum = 4'(xs());
        case (k)
            0: undef = 1;
            1: ovf = 1;
            2: {divu, dz} = 2'h3;
            3: unconditional_trap_op = 1;
            4: divu = 1;
            6: {iend, aerr} = 2'h3;
            default: iend = 1;
        endcase
        @(negedge mclk_i);
        {undef, ovf, divu, dz, unconditional_trap_op, iend, aerr} = 7'h00;
    endtask : pulse

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge mclk_i);
        mmode = 0;
        srst_i = 0;
        run_seq(6'h00, 0);
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                pin_n = 0;
                mx = 1;
                repeat (6) @(negedge mclk_i);
                check("hold", 33'(busy), 33'h1);
                pin_n = 1;
                mmode = 1;
                run_seq(6'h00, 0);
            end
            {pc, sw, cp} = {xs(), 8'(xs())};
            for (int k = 0; k < 6; k++) begin
                pulse(k);
                if (k > 3) begin
                    repeat (4) @(negedge mclk_i);
                    check("quiet", 33'(req), 33'h0);
                end else run_seq(k == 0 ? VN_INVALID : k == 1 ? VN_OVF_TRAP :
                    k == 2 ? VN_ZERO_DIV : VN_TRAP_BASE + 6'(tnum), 1);
            end
            // Address error, trace and interrupt all pending together
            msk = 3'(xs());
            srv = {1'b1, 4'h0, msk, 8'h00};
            srld = 1;
            t = 1;
            @(negedge mclk_i);
            srld = 0;
            // Second pass: the error lands in the ending cycle itself
            aerr = (m == 0);
            irq = 1;
            ivec = 6'h20 + 6'(m);
            ilvl = 3'(xs());
            @(negedge mclk_i);
            aerr = 0;
            pulse(m == 1 ? 6 : 5);
            run_seq(VN_ADDR_ERR, 1);
            run_seq(VN_TRACE, 1);
            run_seq(ivec, 2);
        end
        stop_test();
    end
endmodule : exception_priority_vectoring_test
`default_nettype wire
